// ### design/timer_pkg.sv
// Notes on behaviour
// - Counters and reload registers hold no trusted value
// - Idle timer: 16-bit hidden down counter
// - Thirteenth-bit toggle sets idle tick pending
// - Idle tick request only while enable set
// - Three identical units, counter plus two registers
// - Pin A two-way, pin B input only
// - Three mode bits choose mode and edges
// - PWM: count each cycle, reload A then B
// - PWM toggle option inverts pin A on underflow
// - PWM: A reload sets flag A, B sets B
// - PWM: enables A and B gate own requests
// - Event mode counts selected pin A edges
// - Event mode underflow sets flag A, enable A
// - Event mode pin B rise sets flag B
// - Event mode never drives pin A
// - Capture mode: free-running counter, A/B capture
// - Selected edge copies counter; B rise only paired with A rise
// - Captures set flags A/B, gated by enables
// - Capture underflow sets run bit, shares enable A
// - Mode encodings for PWM, event, capture
// - Run bit starts and stops PWM and event
package timer_pkg;
   localparam int         NUM_UNITS     = 3;
   localparam int         CNT_W         = 16;
   localparam int         ADDR_W        = 8;
   localparam int         TC_NS         = 10;
   localparam int         IDLE_TICK_BIT = 12;
   localparam int         IDLE_TICK_CYC = (1 << IDLE_TICK_BIT) * 10 / TC_NS;
   // Register map: idle word, then one 16-byte block per unit
   localparam logic [7:0] ADDR_IDLE     = 8'h00;
   localparam logic [3:0] UNIT_FIRST    = 4'h1;
   localparam logic [3:0] UNIT_LAST     = 4'h3;
   localparam logic [1:0] REG_CTRL      = 2'h0;
   localparam logic [1:0] REG_COUNT     = 2'h1;
   localparam logic [1:0] REG_RA        = 2'h2;
   localparam logic [1:0] REG_RB        = 2'h3;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   // Mode select values
   localparam logic [2:0] MODE_EVT_RISE = 3'h0;
   localparam logic [2:0] MODE_EVT_FALL = 3'h1;
   localparam logic [2:0] MODE_CAP_RR   = 3'h2;
   localparam logic [2:0] MODE_CAP_FF   = 3'h3;
   localparam logic [2:0] MODE_PWM      = 3'h4;
   localparam logic [2:0] MODE_PWM_TGL  = 3'h5;
   localparam logic [2:0] MODE_CAP_RF   = 3'h6;
   localparam logic [2:0] MODE_CAP_FF2  = 3'h7;

   typedef struct packed {
      logic [2:0] mode;
      logic       run_uf;
      logic       pend_a;
      logic       en_a;
      logic       pend_b;
      logic       en_b;
   } unit_ctrl_t;

   typedef struct packed {
      logic        ctrl;
      logic        count;
      logic        ra;
      logic        rb;
      logic [15:0] data;
   } unit_wr_t;

   typedef struct packed {
      unit_ctrl_t  ctrl;
      logic [15:0] count;
      logic [15:0] ra;
      logic [15:0] rb;
   } unit_view_t;
endpackage

// ### design/timer_top.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module timer_top
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output var  logic                 s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output var  logic                 s_axi_wready,
   // AXI4-Lite write response
   output var  logic [1:0]           s_axi_bresp,
   output var  logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output var  logic                 s_axi_arready,
   // AXI4-Lite read data
   output var  logic [31:0]          s_axi_rdata,
   output var  logic [1:0]           s_axi_rresp,
   output var  logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Timer pins
   input  wire logic [NUM_UNITS-1:0] pin_a_in,
   input  wire logic [NUM_UNITS-1:0] pin_b_in,
   output var  logic [NUM_UNITS-1:0] pin_a_out,
   output var  logic [NUM_UNITS-1:0] pin_a_oe,
   // Interrupt requests
   output var  logic                 irq_idle,
   output var  logic [NUM_UNITS-1:0] irq_a,
   output var  logic [NUM_UNITS-1:0] irq_b
);
   logic [15:0]       idle_timer;
   logic              idle_tick_pending;
   logic              idle_tick_irq_enable;
   logic [ADDR_W-1:0] aw_addr;
   logic              aw_got;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              w_got;
   unit_view_t        view [NUM_UNITS];
   unit_wr_t          unit_wr [NUM_UNITS];

   ////////////////////////////////////////////////////////////////////
   // Register lookup shared by reads and by write merging
   function automatic logic [32:0] lookup(input logic [ADDR_W-1:0] a);
      logic [3:0]  blk;
      logic [1:0]  sel;
      logic [1:0]  idx;
      logic [15:0] v;
      blk    = a[7:4];
      sel    = a[3:2];
      idx    = 2'(blk - UNIT_FIRST);
      v      = 16'h0000;
      lookup = {1'b0, 32'h0000_0000};
      if (a[7:2] == ADDR_IDLE[7:2]) begin
         lookup = {1'b1, 30'h0, idle_tick_pending, idle_tick_irq_enable};
      end else if (blk >= UNIT_FIRST && blk <= UNIT_LAST) begin
         case (sel)
            REG_CTRL:  v = {8'h00, view[idx].ctrl};
            REG_COUNT: v = view[idx].count;
            REG_RA:    v = view[idx].ra;
            REG_RB:    v = view[idx].rb;
            default:   v = 16'h0000;
         endcase
         lookup = {1'b1, 16'h0000, v};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Write path decode: address and data may arrive in either order
   wire        aw_take   = s_axi_awvalid & s_axi_awready;
   wire        w_take    = s_axi_wvalid & s_axi_wready;
   wire        b_take    = s_axi_bvalid & s_axi_bready;
   wire        wr_fire   = aw_got & w_got & ~s_axi_bvalid;
   logic [32:0] wr_old;
   wire        wr_ok     = wr_old[32];
   wire [31:0] wr_mask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] wr_new    = (wr_old[31:0] & ~wr_mask) | (w_data & wr_mask);
   wire [3:0]  wr_blk    = aw_addr[7:4];
   wire [1:0]  wr_sel    = aw_addr[3:2];
   wire        wr_idle   = wr_fire & (aw_addr[7:2] == ADDR_IDLE[7:2]);

   // Read path decode
   wire        ar_take   = s_axi_arvalid & s_axi_arready;
   wire        r_take    = s_axi_rvalid & s_axi_rready;
   logic [32:0] rd_word;

   // Both lookups sit in one process: it wakes on register changes as well
   // as on address changes, which a continuous call of the function would miss
   always_comb begin
      wr_old  = lookup(aw_addr);
      rd_word = lookup(s_axi_araddr);
   end

   // Idle timer tick: bit 12 flips on the edge after the low bits are zero
   wire        idle_tick = (idle_timer[IDLE_TICK_BIT-1:0] == 12'h000);
   wire        next_idle_pending = (wr_idle ? wr_new[1] : idle_tick_pending) | idle_tick;

   ////////////////////////////////////////////////////////////////////
   // Write address and data holding
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_addr <= '0;
         aw_got  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         w_got   <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         aw_got <= (aw_got | aw_take) & ~b_take;
         w_got  <= (w_got | w_take) & ~b_take;
      end
   end

   // Ready flags drop on each handshake and return once the response is taken
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= (s_axi_awready & ~aw_take) | b_take;
         s_axi_wready  <= (s_axi_wready & ~w_take) | b_take;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (b_take) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one read in flight, answer one cycle after address
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word[31:0];
            s_axi_rresp   <= rd_word[32] ? RESP_OKAY : RESP_SLVERR;
         end else if (r_take) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Idle timer: always counting, software cannot see or load it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_timer <= CNT_RESET;
      end else begin
         idle_timer <= 16'(idle_timer - 16'h0001);
      end
   end

   // Idle tick flag and its gated request; the set wins over a clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_tick_pending    <= 1'b0;
         idle_tick_irq_enable <= 1'b0;
         irq_idle             <= 1'b0;
      end else begin
         idle_tick_pending    <= next_idle_pending;
         if (wr_idle) begin
            idle_tick_irq_enable <= wr_new[0];
         end
         irq_idle <= idle_tick_irq_enable & idle_tick_pending;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Three identical units, each with its own write strobes
   for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
      localparam logic [3:0] BLK = 4'(UNIT_FIRST + 4'(i));
      wire hit = wr_fire & (wr_blk == BLK);
      assign unit_wr[i] = '{ctrl:  hit & (wr_sel == REG_CTRL),
                            count: hit & (wr_sel == REG_COUNT),
                            ra:    hit & (wr_sel == REG_RA),
                            rb:    hit & (wr_sel == REG_RB),
                            data:  wr_new[15:0]};

      timer_unit u_unit (
         .sys_clk   (sys_clk),
         .rst_n     (rst_n),
         .pin_a_in  (pin_a_in[i]),
         .pin_b_in  (pin_b_in[i]),
         .pin_a_out (pin_a_out[i]),
         .pin_a_oe  (pin_a_oe[i]),
         .wr        (unit_wr[i]),
         .view      (view[i]),
         .irq_a     (irq_a[i]),
         .irq_b     (irq_b[i])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Cycle counter between idle ticks, for the tick period check only
   logic [15:0] tick_gap;
   logic        tick_seen;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_gap  <= 16'h0000;
         tick_seen <= 1'b0;
      end else begin
         tick_gap  <= idle_tick ? 16'h0001 : 16'(tick_gap + 16'h0001);
         tick_seen <= tick_seen | idle_tick;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_idle_runs: assert property (1'b1 |=> idle_timer == 16'($past(idle_timer) - 16'h0001))
      else $error("Idle timer did not count down");
   a_idle_tick_set: assert property (idle_tick |=> idle_tick_pending)
      else $error("Idle tick did not set pending");
   a_idle_tick_gap: assert property (idle_tick && tick_seen |-> tick_gap == 16'(IDLE_TICK_CYC))
      else $error("Idle tick period wrong");
   a_idle_irq_gate: assert property (irq_idle |-> $past(idle_tick_irq_enable) && $past(idle_tick_pending))
      else $error("Idle request without enable and pending");
   a_idle_irq_rise: assert property (idle_tick_irq_enable && idle_tick_pending && !wr_fire |=> irq_idle)
      else $error("Idle request missing");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped before taken");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped before taken");
   a_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("Read not answered in one cycle");
   a_write_answer: assert property (aw_take && w_take |=> ##1 s_axi_bvalid)
      else $error("Write not answered in two cycles");

   c_idle_irq: cover property (idle_tick_irq_enable ##1 idle_tick ##2 irq_idle);
   c_write_split: cover property (aw_take && !w_take ##[1:4] w_take);
   c_read_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ### design/timer_unit.sv
`timescale 1ns/1ns
`default_nettype none
module timer_unit
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Pins
   input  wire logic pin_a_in,
   input  wire logic pin_b_in,
   output var  logic pin_a_out,
   output var  logic pin_a_oe,
   // Register side
   input  wire unit_wr_t wr,
   output var  unit_view_t view,
   output var  logic irq_a,
   output var  logic irq_b
);
   unit_ctrl_t  ctrl;
   unit_ctrl_t  next_ctrl;
   logic [15:0] count;
   logic [15:0] ra;
   logic [15:0] rb;
   logic        phase;
   logic        a_s1, a_s2, a_s3;
   logic        b_s1, b_s2, b_s3;

   ////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers, third flop only for edge detection
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {a_s1, a_s2, a_s3} <= 3'h0;
         {b_s1, b_s2, b_s3} <= 3'h0;
      end else begin
         {a_s3, a_s2, a_s1} <= {a_s2, a_s1, pin_a_in};
         {b_s3, b_s2, b_s1} <= {b_s2, b_s1, pin_b_in};
      end
   end

   // Edge and mode decode
   wire a_rise    = a_s2 & ~a_s3;
   wire a_fall    = ~a_s2 & a_s3;
   wire b_rise    = b_s2 & ~b_s3;
   wire b_fall    = ~b_s2 & b_s3;
   wire is_pwm    = (ctrl.mode[2:1] == 2'b10);
   wire is_evt    = (ctrl.mode[2:1] == 2'b00);
   wire is_cap    = ctrl.mode[1];
   wire toggle_en = is_pwm & (ctrl.mode == MODE_PWM_TGL);
   wire evt_edge  = ctrl.mode[0] ? a_fall : a_rise;
   wire cap_a     = is_cap & (ctrl.mode[0] ? a_fall : a_rise);
   wire cap_b     = is_cap & ((ctrl.mode == MODE_CAP_RR) ? b_rise : b_fall);
   // Capture mode runs regardless of the run bit, which is its flag there
   wire tick      = is_cap | (ctrl.run_uf & (is_pwm | (is_evt & evt_edge)));
   wire uf        = tick & (count == 16'h0000);
   wire [15:0] reload = phase ? rb : ra;
   wire set_a     = (is_pwm & uf & ~phase) | (is_evt & uf) | cap_a;
   wire set_b     = (is_pwm & uf & phase) | (is_evt & b_rise) | cap_b;
   wire set_uf    = is_cap & uf;
   wire [15:0] next_count = wr.count ? wr.data :
                            (uf & is_pwm) ? reload :
                            (uf & is_evt) ? ra :
                            tick ? 16'(count - 16'h0001) : count;
   wire next_phase = (is_pwm & ctrl.run_uf) ? (phase ^ uf) : 1'b0;

   // Software writes first, hardware sets on top so no event is lost
   always_comb begin
      next_ctrl = wr.ctrl ? unit_ctrl_t'(wr.data[7:0]) : ctrl;
      next_ctrl.pend_a = next_ctrl.pend_a | set_a;
      next_ctrl.pend_b = next_ctrl.pend_b | set_b;
      next_ctrl.run_uf = next_ctrl.run_uf | set_uf;
   end

   ////////////////////////////////////////////////////////////////////
   // Counter and registers; reset value is never relied upon
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= CNT_RESET;
         ra    <= CNT_RESET;
         rb    <= CNT_RESET;
      end else begin
         count <= next_count;
         ra    <= cap_a ? count : (wr.ra ? wr.data : ra);
         rb    <= cap_b ? count : (wr.rb ? wr.data : rb);
      end
   end

   // Control, phase, pin drive and requests
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl      <= unit_ctrl_t'(CTRL_RESET);
         phase     <= 1'b0;
         pin_a_out <= 1'b0;
         pin_a_oe  <= 1'b0;
         irq_a     <= 1'b0;
         irq_b     <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         phase     <= next_phase;
         pin_a_out <= pin_a_out ^ (uf & toggle_en);
         pin_a_oe  <= is_pwm;
         irq_a     <= ctrl.en_a & (ctrl.pend_a | (is_cap & ctrl.run_uf));
         irq_b     <= ctrl.en_b & ctrl.pend_b;
      end
   end

   assign view = '{ctrl: ctrl, count: count, ra: ra, rb: rb};

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_pwm_reload_a: assert property (is_pwm && uf && !phase && !wr.count |=> count == $past(ra))
      else $error("PWM underflow did not load register A");
   a_pwm_alternate: assert property (is_pwm && uf && !wr.ctrl |=> phase != $past(phase))
      else $error("PWM reload source did not alternate");
   a_pwm_pin_toggle: assert property (toggle_en && uf |=> pin_a_out != $past(pin_a_out))
      else $error("PWM underflow did not toggle pin A");
   a_flag_b_set: assert property (set_b |=> ctrl.pend_b)
      else $error("Pending B not set by its event");
   a_evt_pin_idle: assert property (is_evt && !wr.ctrl |=> ##1 !pin_a_oe)
      else $error("Pin A driven in event mode");
   a_cap_copy: assert property (cap_a |=> ra == $past(count) && ctrl.pend_a)
      else $error("Capture A did not copy counter");
   a_cap_uf_irq: assert property (set_uf && ctrl.en_a && !wr.ctrl |=> ##1 irq_a)
      else $error("Capture underflow did not request A");
   c_pwm_uf: cover property (is_pwm && uf && phase);
   c_cap_both: cover property (cap_a && cap_b);
endmodule
`default_nettype wire

// ### verif/multimode_timer_block_bench.sv
`timescale 1ns/1ns
`default_nettype none
module multimode_timer_block_bench;
   import timer_pkg::*;
   logic                 sys_clk, rst_n;
   logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
   logic [31:0]          s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp, resp;
   logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                 s_axi_rvalid, s_axi_rready, irq_idle;
   logic [NUM_UNITS-1:0] pin_a_in, pin_b_in, pin_a_out, pin_a_oe, irq_a, irq_b;
   int                   error_cnt, check_count, i1, i2, k;
   // Register rows: address, write value, read-back, response
   logic [7:0]           t_addr [5] = '{8'h18, 8'h2c, 8'h3c, 8'h40, 8'h0c};
   logic [31:0]          t_wr   [5] = '{32'hffff1234, 32'h0000abcd, 32'h00010001, 32'hffffffff, 32'h1};
   logic [31:0]          t_rd   [5] = '{32'h1234, 32'habcd, 32'h0001, 32'h0, 32'h0};
   logic [1:0]           t_rsp  [5] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR, RESP_SLVERR};

   timer_top DUT (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .pin_a_in, .pin_b_in, .pin_a_out, .pin_a_oe, .irq_idle, .irq_a, .irq_b);
   pin_source SRC (.sys_clk, .pin_a_out, .pin_a_oe, .pin_a_in, .pin_b_in);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic give_up;
      error_cnt++;
      tally_and_finish();
   endtask

   // AXI write: both channels offered together, bready held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 100) give_up();
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // One idle edge, so a following call never re-drives bready in this step
      @(posedge sys_clk);
   endtask

   // AXI read: data and response taken at the rvalid edge
   task automatic rd(input logic [7:0] a);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 100) give_up();
      rdv  = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      // One idle edge, so a following call never re-drives rready in this step
      @(posedge sys_clk);
   endtask

   // Cycles until pin A of unit u changes level
   task automatic wait_tgl(input int u, output int n);
      logic prev;
      prev = pin_a_out[u];
      for (n = 1; n < 300; n++) begin
         @(posedge sys_clk);
         if (pin_a_out[u] !== prev) break;
      end
      if (n == 300) give_up();
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(8'h10);
      chk(rdv, 32'h0);
      // Row loop: 16-bit registers, unmapped places refused
      for (k = 0; k < 5; k++) begin
         wr(t_addr[k], t_wr[k]);
         chk(32'(resp), 32'(t_rsp[k]));
         rd(t_addr[k]);
         chk(rdv, t_rd[k]);
         chk(32'(resp), 32'(t_rsp[k]));
      end
      // Every mode code; a far count keeps the capture codes clear of underflow
      wr(8'h34, 32'h8000);
      for (k = 0; k < 8; k++) begin
         wr(8'h30, 32'(k << 5));
         repeat (3) @(posedge sys_clk);
         chk(32'(pin_a_oe[2]), 32'(k == 4 || k == 5));
         rd(8'h30);
         chk(rdv, 32'(k << 5));
      end
      // PWM with toggle on unit 1: half periods RA+1 then RB+1
      wr(8'h28, 32'd3);
      wr(8'h2c, 32'd5);
      wr(8'h24, 32'd20);
      wr(8'h20, 32'hb4);
      wait_tgl(1, i1);
      wait_tgl(1, i1);
      wait_tgl(1, i2);
      chk(32'(i1), 32'd4);
      chk(32'(i2), 32'd6);
      chk(32'(pin_a_oe[1]), 32'h1);
      rd(8'h20);
      chk(rdv, 32'hbe);
      chk(32'({irq_a[1], irq_b[1]}), 32'h2);
      wr(8'h20, 32'h80);
      rd(8'h24);
      i1 = rdv;
      repeat (5) @(posedge sys_clk);
      rd(8'h24);
      chk(rdv, 32'(i1));
      // Event counting on unit 0 from count 2, reload 5
      wr(8'h18, 32'd5);
      wr(8'h14, 32'd2);
      wr(8'h10, 32'h15);
      SRC.pulse(1'b0, 0);
      SRC.pulse(1'b0, 0);
      rd(8'h10);
      chk(rdv, 32'h15);
      SRC.pulse(1'b0, 0);
      rd(8'h10);
      chk(rdv, 32'h1d);
      rd(8'h14);
      chk(rdv, 32'd5);
      SRC.pulse(1'b1, 0);
      rd(8'h10);
      chk(rdv, 32'h1f);
      chk(32'({irq_a[0], irq_b[0], pin_a_oe[0]}), 32'h6);
      // Second event code: the rise is ignored, only the fall counts
      wr(8'h10, 32'h30);
      SRC.pulse(1'b0, 0);
      rd(8'h14);
      chk(rdv, 32'd4);
      // Capture on unit 2, rising A, then underflow and falling B
      wr(8'h34, 32'h8000);
      wr(8'h30, 32'h44);
      SRC.pulse(1'b0, 2);
      rd(8'h38);
      chk(32'((16'h8000 - rdv[15:0]) < 16'd80 && rdv[15:0] != 16'h8000), 32'h1);
      chk(32'(irq_a[2]), 32'h1);
      wr(8'h34, 32'd2);
      repeat (10) @(posedge sys_clk);
      rd(8'h30);
      chk(rdv, 32'h5c);
      wr(8'h30, 32'hc1);
      SRC.pulse(1'b1, 2);
      rd(8'h30);
      chk(rdv, 32'hc3);
      chk(32'(irq_b[2]), 32'h1);
      // Idle tick: cycles from clearing the flag to the next request
      wr(8'h00, 32'h1);
      for (i1 = 0; i1 < 5000 && irq_idle !== 1'b1; i1++) @(posedge sys_clk);
      if (i1 == 5000) give_up();
      wr(8'h00, 32'h1);
      for (i1 = 0; i1 < 5000 && irq_idle !== 1'b1; i1++) @(posedge sys_clk);
      if (i1 == 5000) give_up();
      chk(32'(i1 > 4090 && i1 < 4100), 32'h1);
      wr(8'h00, 32'h2);
      repeat (2) @(posedge sys_clk);
      chk(32'(irq_idle), 32'h0);
      rd(8'h00);
      chk(rdv, 32'h2);
      // Reset in mid-run drops drives and requests
      rst_n <= 1'b0;
      @(posedge sys_clk);
      chk(32'({pin_a_oe, irq_a, irq_b, irq_idle, s_axi_bvalid}), 32'h0);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(8'h20);
      chk(rdv, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ### verif/pin_source.sv
`timescale 1ns/1ns
`default_nettype none
module pin_source
   import timer_pkg::*;
(
   // Clock
   input  wire logic                 sys_clk,
   // Unit side of the pins
   input  wire logic [NUM_UNITS-1:0] pin_a_out,
   input  wire logic [NUM_UNITS-1:0] pin_a_oe,
   output var  logic [NUM_UNITS-1:0] pin_a_in,
   output var  logic [NUM_UNITS-1:0] pin_b_in
);
   logic [NUM_UNITS-1:0] ext_a;

   // Pin A wire: the unit wins while it drives, else the outside source
   assign pin_a_in = (pin_a_oe & pin_a_out) | (~pin_a_oe & ext_a);

   initial begin
      ext_a    = '0;
      pin_b_in = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One full pulse; each level is held for four cycles so the sync sees it
   task automatic pulse(input bit on_b, input int u);
      repeat (4) @(posedge sys_clk);
      if (on_b) pin_b_in[u] <= 1'b1;
      else ext_a[u] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      if (on_b) pin_b_in[u] <= 1'b0;
      else ext_a[u] <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire
